// >>> src/mmbd_pkg.sv
// memory map and bank decode constants
// assumes a single core clock domain and a synchronous active-low reset
package mmbd_pkg;
    // -----------------------------------------------------------------
    // program space
    // -----------------------------------------------------------------
    localparam int PC_W = 13;
    localparam int IW_W = 14;
    localparam int PROG_IMPL_W = 10;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam logic [12:0] PROG_IMPL_LAST = 13'h03ff;
    // -----------------------------------------------------------------
    // data space
    // -----------------------------------------------------------------
    localparam int DADDR_W = 8;
    localparam int DIR_W = 7;
    localparam int RAM_DEPTH = 64;
    localparam int RAM_AW = 6;
    localparam logic [6:0] SFR_LAST = 7'h1f;
    localparam logic [6:0] GPR_FIRST = 7'h20;
    localparam logic [6:0] GPR_LAST = 7'h5f;
    localparam logic [6:0] IND_ADDR = 7'h00;
    localparam logic [6:0] STATUS_ADDR = 7'h03;
    localparam logic [6:0] FSP_ADDR = 7'h04;
    localparam int BANK_BIT_POS = 5;
    localparam int UPPER_BANK_POS = 6;
    localparam int IND_BANK_POS = 7;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] FSP_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        MMBD_REGION_SFR = 2'b00,
        MMBD_REGION_GPR = 2'b01,
        MMBD_REGION_NONE = 2'b10
    } mmbd_region_e;
endpackage : mmbd_pkg

// >>> src/mmbd_ram_if.sv
// request carrier between the decoder and the shared data ram
// assumes both ends sit on the core clock
`timescale 1ns/1ps
interface mmbd_ram_if;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output we, output addr, output wdata, input rdata);
    modport slave (input we, input addr, input wdata, output rdata);
endinterface : mmbd_ram_if

// >>> src/mmbd_ram.sv
// 64 x 8 general purpose ram shared by both banks
// assumes addresses already folded to the 6-bit window
`timescale 1ns/1ps
module mmbd_ram
    import mmbd_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // access
    mmbd_ram_if.slave port
);
    logic [7:0] mem [RAM_DEPTH];

    // asynchronous read so the decoder sees data in the access cycle
    assign port.rdata = mem[port.addr];

    always_ff @(posedge ref_clk_in) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata; // see [RQ12]
        end
    end
endmodule : mmbd_ram

// >>> src/mmbd_top.sv
// program address fold and banked data memory decode
// assumes the cpu core drives requests on ref_clk_in; status and file select pointer are the only control registers held here, the rest sit outside
// Function
// [RQ1] the program counter is 13 bits, spanning 8K words of 14 bits.
// [RQ2] only words 0000h to 03FFh physically exist.
// [RQ3] fetches above 03FFh wrap into the lowest 1K words.
// [RQ4] after reset fetch starts at 0000h.
// [RQ5] an interrupt redirects fetch to 0004h.
// [RQ6] data memory is two banks holding general registers and control registers.
// [RQ7] the lowest 32 addresses of each bank decode to control registers.
// [RQ8] addresses 20h-5Fh reach one ram shared by both banks.
// [RQ9] other locations read zero and ignore writes.
// [RQ10] status bit 5 selects bank 0 or bank 1.
// [RQ11] software keeps status bits 7 and 6 at zero.
// [RQ12] 64 ram bytes are reachable directly or through the file select pointer.
// [RQ13] the full data address is the bank bit prefixed to the 7-bit direct address.
`timescale 1ns/1ps
module mmbd_top
    import mmbd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // program counter control
    input wire logic pc_advance_in,
    input wire logic pc_load_in,
    input wire logic [12:0] pc_target_in,
    input wire logic int_take_in,
    // data access
    input wire logic d_req_in,
    input wire logic d_we_in,
    input wire logic [6:0] d_addr_in,
    input wire logic [7:0] d_wdata_in,
    // control register file outside
    input wire logic [7:0] sfr_rdata_in,
    // program side
    output logic [12:0] pc_out,
    output logic [9:0] prog_addr_out,
    // data side
    output logic [7:0] d_rdata_out,
    output logic d_valid_out,
    output logic [7:0] d_full_addr_out,
    output logic sfr_sel_out,
    output logic sfr_we_out,
    output logic [7:0] sfr_wdata_out,
    output logic bank_select_bit_out,
    output logic [7:0] file_select_pointer_out
);
    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    logic [12:0] pc_reg;
    logic [12:0] pc_next;

    always_comb begin
        pc_next = pc_reg;
        if (int_take_in) begin
            pc_next = INT_VECTOR; // see [RQ5]
        end else if (pc_load_in) begin
            pc_next = pc_target_in;
        end else if (pc_advance_in) begin
            pc_next = 13'(pc_reg + 13'h0001); // see [RQ1]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            pc_reg <= RESET_VECTOR; // see [RQ4]
            prog_addr_out <= RESET_VECTOR[PROG_IMPL_W-1:0];
        end else begin
            pc_reg <= pc_next;
            // upper pc bits are dropped: the array only holds 1K words
            prog_addr_out <= pc_next[PROG_IMPL_W-1:0]; // see [RQ2] see [RQ3]
        end
    end
    assign pc_out = pc_reg;

    // ---------------------------------------------------------------
    // status bank bits and file select pointer
    // ---------------------------------------------------------------
    logic [7:0] status_reg;
    logic [7:0] fsp_reg;
    logic [6:0] eff_addr;
    logic eff_bank;
    logic [7:0] full_addr;
    mmbd_region_e region;

    // indirect access through location 00h uses the pointer
    always_comb begin
        if (d_addr_in == IND_ADDR) begin
            eff_addr = fsp_reg[DIR_W-1:0];
            eff_bank = fsp_reg[IND_BANK_POS]; // see [RQ12]
        end else begin
            eff_addr = d_addr_in;
            eff_bank = status_reg[BANK_BIT_POS]; // see [RQ10]
        end
        full_addr = {eff_bank, eff_addr}; // see [RQ13]
    end

    always_comb begin
        if (eff_addr <= SFR_LAST) begin
            region = MMBD_REGION_SFR; // see [RQ7]
        end else if (eff_addr <= GPR_LAST) begin
            region = MMBD_REGION_GPR; // see [RQ8]
        end else begin
            region = MMBD_REGION_NONE; // see [RQ9]
        end
    end

    logic sfr_wr;
    assign sfr_wr = d_req_in && d_we_in && (region == MMBD_REGION_SFR);

    // status and pointer live at the same slot in both banks
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            status_reg <= STATUS_RESET;
        end else if (sfr_wr && eff_addr == STATUS_ADDR) begin
            // bits 7:6 stored as written; software keeps them zero
            status_reg <= d_wdata_in; // see [RQ11]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            fsp_reg <= FSP_RESET;
        end else if (sfr_wr && eff_addr == FSP_ADDR) begin
            fsp_reg <= d_wdata_in;
        end
    end

    // ---------------------------------------------------------------
    // shared ram
    // ---------------------------------------------------------------
    mmbd_ram_if ram_bus ();
    // bank bit ignored: both banks fold onto one array
    assign ram_bus.we = d_req_in && d_we_in && (region == MMBD_REGION_GPR); // see [RQ8]
    assign ram_bus.addr = 6'(eff_addr - GPR_FIRST);
    assign ram_bus.wdata = d_wdata_in;

    mmbd_ram u_ram (
        .ref_clk_in(ref_clk_in),
        .port(ram_bus)
    );

    // ---------------------------------------------------------------
    // read data and outward strobes, all registered
    // ---------------------------------------------------------------
    logic [7:0] rdata_next;
    always_comb begin
        unique case (region)
            MMBD_REGION_SFR: begin
                if (eff_addr == STATUS_ADDR) begin
                    rdata_next = status_reg;
                end else if (eff_addr == FSP_ADDR) begin
                    rdata_next = fsp_reg;
                end else begin
                    rdata_next = sfr_rdata_in;
                end
            end
            MMBD_REGION_GPR: rdata_next = ram_bus.rdata;
            default: rdata_next = BYTE_ZERO; // see [RQ9]
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            d_rdata_out <= BYTE_ZERO;
            d_valid_out <= 1'b0;
            d_full_addr_out <= BYTE_ZERO;
            sfr_sel_out <= 1'b0;
            sfr_we_out <= 1'b0;
            sfr_wdata_out <= BYTE_ZERO;
        end else begin
            d_rdata_out <= d_req_in ? rdata_next : BYTE_ZERO;
            d_valid_out <= d_req_in;
            d_full_addr_out <= full_addr; // see [RQ6]
            sfr_sel_out <= d_req_in && (region == MMBD_REGION_SFR);
            sfr_we_out <= sfr_wr;
            sfr_wdata_out <= d_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            bank_select_bit_out <= STATUS_RESET[BANK_BIT_POS];
            file_select_pointer_out <= FSP_RESET;
        end else begin
            bank_select_bit_out <= status_reg[BANK_BIT_POS];
            file_select_pointer_out <= fsp_reg;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_int_taken;
        int_take_in;
    endsequence

    a_pc_reset_vec: assert property (@(posedge ref_clk_in) !rstn_in |=> pc_out == RESET_VECTOR) // see [RQ4]
        else $error("pc not at reset vector after reset");
    a_pc_int_vec: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        s_int_taken |=> pc_out == INT_VECTOR) // see [RQ5]
        else $error("interrupt did not redirect to vector");
    a_prog_addr_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        prog_addr_out == pc_out[PROG_IMPL_W-1:0]) // see [RQ3]
        else $error("program address not folded from pc");
    a_pc_increment: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        pc_advance_in && !pc_load_in && !int_take_in |=> pc_out == 13'($past(pc_out) + 13'h0001)) // see [RQ1]
        else $error("pc did not advance by one");
    a_unimpl_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        d_req_in && region == MMBD_REGION_NONE |=> d_rdata_out == BYTE_ZERO) // see [RQ9]
        else $error("unimplemented location read nonzero");
    a_sfr_low_slots: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        d_req_in && eff_addr <= SFR_LAST |=> sfr_sel_out) // see [RQ7]
        else $error("low slot not decoded as control register");
    a_bank_prefix: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        d_addr_in != IND_ADDR |=> d_full_addr_out == {$past(status_reg[BANK_BIT_POS]), $past(d_addr_in)}) // see [RQ13]
        else $error("full address not bank-prefixed");
    a_gpr_shared: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        d_req_in && d_we_in && region == MMBD_REGION_GPR ##1
        d_req_in && !d_we_in && region == MMBD_REGION_GPR && eff_addr == $past(eff_addr)
        |=> d_rdata_out == $past(d_wdata_in, 2)) // see [RQ8]
        else $error("shared ram did not return written byte");
    a_bank_sel_out: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        sfr_wr && eff_addr == STATUS_ADDR |=> ##1 bank_select_bit_out == $past(d_wdata_in[BANK_BIT_POS], 2)) // see [RQ10]
        else $error("bank select bit not taken from status bit 5");
endmodule : mmbd_top

// >>> tb/mmbd_sfr_model.sv
// control register file standing beside the decoder
// assumes reads answer combinationally on the direct address of the request cycle
`timescale 1ns/1ps
module mmbd_sfr_model
    import mmbd_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // request
    input wire logic [6:0] d_addr_in,
    // read answer
    output logic [7:0] sfr_rdata_out
);
    logic [7:0] noise_reg = 8'h3c;
    // outside the control window nobody drives; keep it moving so stale data shows
    always_ff @(posedge ref_clk_in) begin
        noise_reg <= {noise_reg[6:0], noise_reg[7] ^ noise_reg[5]};
    end
    always_comb begin
        if (d_addr_in <= SFR_LAST) begin
            sfr_rdata_out = {d_addr_in[4:0], 3'h5};
        end else begin
            sfr_rdata_out = noise_reg;
        end
    end
endmodule : mmbd_sfr_model

// >>> tb/memory_map_bank_decode_tb_top.sv
// self-checking bench for the program fold and banked data decode
// assumes package, ram carrier and design compiled first; one 250 MHz clock
`timescale 1ns/1ps
module memory_map_bank_decode_tb_top
    import mmbd_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0, adv = 1'b0, load = 1'b0, itk = 1'b0, req = 1'b0, we = 1'b0;
    logic [12:0] tgt = 13'h0000;
    logic [6:0] addr = 7'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] sfr_rd, rdata, full, sfr_wd, ptr_o, d;
    logic [12:0] pc;
    logic [9:0] pa;
    logic valid, sel, swe, bank_o;
    logic [6:0] a;
    logic [7:0] mem [64];
    logic [7:0] status_m = 8'h18;
    logic [7:0] ptr_m = 8'h00;
    int bad_count = 0;
    int samples_checked = 0;
    int seed_dummy;

    always #2 clk = ~clk;

    mmbd_top i_dut (.ref_clk_in(clk), .rstn_in(rstn), .pc_advance_in(adv), .pc_load_in(load),
        .pc_target_in(tgt), .int_take_in(itk), .d_req_in(req), .d_we_in(we), .d_addr_in(addr),
        .d_wdata_in(wd), .sfr_rdata_in(sfr_rd), .pc_out(pc), .prog_addr_out(pa), .d_rdata_out(rdata),
        .d_valid_out(valid), .d_full_addr_out(full), .sfr_sel_out(sel), .sfr_we_out(swe),
        .sfr_wdata_out(sfr_wd), .bank_select_bit_out(bank_o), .file_select_pointer_out(ptr_o));
    mmbd_sfr_model i_sfr (.ref_clk_in(clk), .d_addr_in(addr), .sfr_rdata_out(sfr_rd));

    // ---------------------------------------------------------------
    // checking and expectation helpers
    // ---------------------------------------------------------------
    // wide enough for the 23-bit program pair {prog_addr, pc}
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [7:0] exp_rd(input logic [6:0] e);
        if (e == STATUS_ADDR) return status_m;
        if (e == FSP_ADDR) return ptr_m;
        if (e <= SFR_LAST) return {e[4:0], 3'h5};
        if (e <= GPR_LAST) return mem[6'(e - GPR_FIRST)];
        return BYTE_ZERO;
    endfunction : exp_rd

    // one access taken at the next edge; request left up so back-to-back calls stay legal
    task automatic acc(input logic w, input logic [6:0] ad, input logic [7:0] dat);
        logic [6:0] e;
        logic b;
        e = (ad == IND_ADDR) ? ptr_m[6:0] : ad;
        b = (ad == IND_ADDR) ? ptr_m[7] : status_m[BANK_BIT_POS];
        req = 1'b1;
        we = w;
        addr = ad;
        wd = dat;
        @(posedge clk);
        #1;
        chk("valid", valid, 1'b1);
        chk("full address", full, {b, e});
        chk("control select", sel, e <= SFR_LAST);
        if (!w) chk("read data", rdata, exp_rd(e));
        // strobe must stay low on reads and on ram or empty-space writes
        chk("control write", swe, w && e <= SFR_LAST);
        chk("control data", sfr_wd, dat);
        if (w && e == STATUS_ADDR) status_m = dat;
        if (w && e == FSP_ADDR) ptr_m = dat;
        if (w && e >= GPR_FIRST && e <= GPR_LAST) mem[6'(e - GPR_FIRST)] = dat;
    endtask : acc

    task automatic pstep(input logic i, input logic l, input logic v, input logic [12:0] t);
        itk = i;
        load = l;
        adv = v;
        tgt = t;
        @(posedge clk);
        #1;
    endtask : pstep

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        seed_dummy = $urandom(32'h48f0);
        repeat (6) @(posedge clk);
        #1;
        chk("reset pc", {pa, pc}, 23'h000000);
        chk("reset bank and pointer", {bank_o, ptr_o}, 9'h000);
        rstn = 1'b1;
        acc(1'b0, STATUS_ADDR, 8'h00);
        for (int i = 32; i < 96; i++) acc(1'b1, 7'(i), 8'($urandom));
        acc(1'b1, STATUS_ADDR, 8'h20);
        acc(1'b0, 7'h05, 8'h00);
        chk("bank bit", bank_o, 1'b1);
        // bank 1 reads the bytes written from bank 0
        for (int i = 0; i < 64; i++) acc(1'b0, 7'(32 + (i * 37) % 64), 8'h00);
        for (int j = 0; j < 2; j++) begin
            acc(1'b1, j ? 7'h7f : 7'h60, 8'hff);
            acc(1'b0, j ? 7'h7f : 7'h60, 8'h00);
        end
        acc(1'b1, FSP_ADDR, 8'hdf);
        acc(1'b0, IND_ADDR, 8'h00);
        acc(1'b1, IND_ADDR, 8'h5a);
        acc(1'b0, 7'h5f, 8'h00);
        chk("pointer", ptr_o, ptr_m);
        for (int k = 0; k < 300; k++) begin
            a = 7'($urandom);
            d = 8'($urandom);
            if (a == STATUS_ADDR) d = d & 8'h20;
            if (a == FSP_ADDR) d = {d[7], 7'(GPR_FIRST + d[5:0])};
            acc(1'($urandom), a, d);
        end
        req = 1'b0;
        for (int k = 0; k < 12; k++) begin
            pstep(1'b0, 1'b1, 1'($urandom), 13'($urandom));
            chk("pc load", {pa, pc}, {tgt[9:0], tgt});
        end
        chk("idle read", {valid, rdata}, 9'h000);
        pstep(1'b1, 1'b1, 1'b1, 13'h1234);
        chk("interrupt pc", {pa, pc}, {10'h004, INT_VECTOR});
        pstep(1'b0, 1'b1, 1'b1, 13'h1fff);
        pstep(1'b0, 1'b0, 1'b1, 13'h0000);
        chk("pc roll", pc, 13'h0000);
        pstep(1'b0, 1'b1, 1'b0, PROG_IMPL_LAST);
        pstep(1'b0, 1'b0, 1'b1, 13'h0000);
        chk("pc above window", {pa, pc}, {10'h000, 13'h0400});
        rstn = 1'b0;
        pstep(1'b0, 1'b0, 1'b1, 13'h0000);
        chk("second reset pc", {pa, pc}, {10'h000, RESET_VECTOR});
        chk("second reset bank and pointer", {bank_o, ptr_o}, 9'h000);
        status_m = STATUS_RESET;
        ptr_m = FSP_RESET;
        rstn = 1'b1;
        acc(1'b0, STATUS_ADDR, 8'h00);
        // advance was left high: one step from the reset vector
        chk("pc after reset", {pa, pc}, {10'h001, 13'h0001});
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule : memory_map_bank_decode_tb_top
